// ===== rtl/irq_flag_polarity_cause.sv
/*
  interrupt flag word with direct and set/clear views, per-bit polarity,
  internal source enable, and reported cause code with request status.
  assumes avalon-mm slave access from a single clock domain; source lines
  are synchronous to clk, and the master id marks core accesses.
*/
`timescale 1ns/1ns
module irq_flag_polarity_cause #(
  parameter int FLAG_W = 16
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic        avs_master_is_core,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             avs_response_err,
  input  wire logic [31:0] source_req,
  output logic      [FLAG_W-1:0] flag_request,
  output logic             core_irq,
  output logic             irq
);

  // event vector width, taken from the package before any use below
  localparam int EVT_W_L = irq_flag_pkg::EVT_W;

  // the bus side needs only two states: the slave always inserts exactly
  // one wait state, so no counter is kept and the answer time is fixed
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } bus_state_t;

  bus_state_t        bus_q;
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] invert_q;
  logic [FLAG_W-1:0] enable_q;
  logic [4:0]        cause_q;
  logic              noreq_q;
  logic [EVT_W_L-1:0] evt_q;
  logic [EVT_W_L-1:0] evt_en_q;
  logic [31:0]       rdata_q;
  logic              err_q;
  logic [31:0]       src_all;
  logic [31:0]       wmask;
  logic              acc;
  logic              wr_go;
  logic              hit;
  logic [4:0]        pick;
  logic              any_req;
  logic              noreq_prev_q;
  logic [EVT_W_L-1:0] evt_set;
  logic [EVT_W_L-1:0] evt_clr;

  // byte enables widened to a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // one wait state: request is accepted in idle, answered in done
  assign acc             = (avs_read | avs_write) && bus_q == BUS_IDLE;
  assign wr_go           = avs_write && bus_q == BUS_DONE;
  assign avs_waitrequest = (avs_read | avs_write) && bus_q == BUS_IDLE;
  assign avs_readdata    = rdata_q;
  assign avs_response_err = err_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_q <= BUS_IDLE;
    end else begin
      case (bus_q)
        BUS_IDLE: if (avs_read | avs_write) bus_q <= BUS_DONE;
        default:  bus_q <= BUS_IDLE;
      endcase
    end
  end

  // address decode; reserved bits and unmapped offsets read zero
  always_comb begin
    hit = 1'b1;
    if (avs_address == irq_flag_pkg::OFS_FLAG_DIRECT) begin
    end else if (avs_address == irq_flag_pkg::OFS_FLAG_SETCLR) begin
    end else if (avs_address == irq_flag_pkg::OFS_INVERT_SEL) begin
    end else if (avs_address == irq_flag_pkg::OFS_SRC_ENABLE) begin
    end else if (avs_address == irq_flag_pkg::OFS_CUR_STATUS) begin
    end else if (avs_address == irq_flag_pkg::OFS_EVT_STATUS) begin
    end else if (avs_address == irq_flag_pkg::OFS_EVT_ENABLE) begin
    end else if (avs_address == irq_flag_pkg::OFS_EVT_CLEAR) begin
    end else begin
      hit = 1'b0;
    end
  end

  // read data captured at accept, so it stands at the releasing edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (acc) begin
      err_q   <= ~hit;
      rdata_q <= 32'h0000_0000;
      if (avs_read) begin
        if (avs_address == irq_flag_pkg::OFS_FLAG_DIRECT) begin
          rdata_q[FLAG_W-1:0] <= flag_q;
        end else if (avs_address == irq_flag_pkg::OFS_FLAG_SETCLR) begin
          rdata_q[FLAG_W-1:0] <= flag_q;
        end else if (avs_address == irq_flag_pkg::OFS_INVERT_SEL) begin
          rdata_q[FLAG_W-1:0] <= invert_q;
        end else if (avs_address == irq_flag_pkg::OFS_SRC_ENABLE) begin
          rdata_q[FLAG_W-1:0] <= enable_q;
        end else if (avs_address == irq_flag_pkg::OFS_CUR_STATUS) begin
          rdata_q[irq_flag_pkg::NOREQ_BIT] <= noreq_q;
          rdata_q[irq_flag_pkg::CAUSE_LSB +: 5] <= cause_q;
        end else if (avs_address == irq_flag_pkg::OFS_EVT_STATUS) begin
          rdata_q[EVT_W_L-1:0] <= evt_q;
        end else if (avs_address == irq_flag_pkg::OFS_EVT_ENABLE) begin
          rdata_q[EVT_W_L-1:0] <= evt_en_q;
        end else begin
          rdata_q <= 32'h0000_0000;
        end
      end
    end
  end

  // shared flag storage; both views write the same word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= irq_flag_pkg::FLAG_RST;
    end else if (wr_go && avs_address == irq_flag_pkg::OFS_FLAG_DIRECT) begin
      flag_q <= (flag_q & ~wmask[FLAG_W-1:0])
              | (avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0]);
    end else if (wr_go && avs_address == irq_flag_pkg::OFS_FLAG_SETCLR) begin
      if (avs_master_is_core) begin
        flag_q <= flag_q | (avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0]);
      end else begin
        flag_q <= flag_q & ~(avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0]);
      end
    end
  end

  // polarity select and source enable words
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      invert_q <= irq_flag_pkg::INVERT_RST;
      enable_q <= irq_flag_pkg::SRC_ENABLE_RST;
    end else if (wr_go && avs_address == irq_flag_pkg::OFS_INVERT_SEL) begin
      invert_q <= (invert_q & ~wmask[FLAG_W-1:0])
                | (avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0]);
    end else if (wr_go && avs_address == irq_flag_pkg::OFS_SRC_ENABLE) begin
      enable_q <= (enable_q & ~wmask[FLAG_W-1:0])
                | (avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0]);
    end
  end

  // per-bit request and the gated own-flag source
  assign flag_request = flag_q ^ invert_q;

  // full source vector; the own-flag slot is replaced, reserved slot dropped
  always_comb begin
    src_all = source_req;
    src_all[irq_flag_pkg::SRC_FLAG_UNIT] = |(flag_request & enable_q);
    src_all[irq_flag_pkg::SRC_RESERVED]  = 1'b0;
  end

  // lowest code wins; the code is the source index, so the table
  // of external, serial, dma, timer and pci slots is positional
  always_comb begin
    pick = irq_flag_pkg::CAUSE_RST;
    for (int i = irq_flag_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (src_all[i]) pick = 5'(i);
    end
  end
  assign any_req = |src_all;

  // cause keeps its last value once requests go away, so it is
  // meaningless while the no-request bit is set
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause_q      <= irq_flag_pkg::CAUSE_RST;
      noreq_q      <= 1'b1;
      noreq_prev_q <= 1'b1;
    end else begin
      noreq_q      <= ~any_req;
      noreq_prev_q <= noreq_q;
      if (any_req) cause_q <= pick;
    end
  end
  assign core_irq = ~noreq_q;

  // sticky events: new report, own-flag request while high
  assign evt_set[irq_flag_pkg::EVT_REPORT]   = noreq_prev_q & ~noreq_q;
  assign evt_set[irq_flag_pkg::EVT_FLAG_REQ] = |(flag_request & enable_q);
  assign evt_clr = (wr_go && avs_address == irq_flag_pkg::OFS_EVT_CLEAR)
                 ? avs_writedata[EVT_W_L-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_q    <= '0;
      evt_en_q <= '0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      if (wr_go && avs_address == irq_flag_pkg::OFS_EVT_ENABLE) begin
        evt_en_q <= avs_writedata[EVT_W_L-1:0];
      end
    end
  end
  assign irq = |(evt_q & evt_en_q);

  a_core_sets: assert property (@(posedge clk) disable iff (!resetn)
    wr_go && avs_address == irq_flag_pkg::OFS_FLAG_SETCLR && avs_master_is_core
    |=> ((flag_q & $past(avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0]))
         == $past(avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0])))
    else $error("core set write did not set flags");
  a_other_clears: assert property (@(posedge clk) disable iff (!resetn)
    wr_go && avs_address == irq_flag_pkg::OFS_FLAG_SETCLR && !avs_master_is_core
    |=> ((flag_q & $past(avs_writedata[FLAG_W-1:0] & wmask[FLAG_W-1:0])) == '0))
    else $error("master clear write did not clear flags");
  a_direct_load: assert property (@(posedge clk) disable iff (!resetn)
    wr_go && avs_address == irq_flag_pkg::OFS_FLAG_DIRECT && avs_byteenable == 4'hf
    |=> flag_q == $past(avs_writedata[FLAG_W-1:0]))
    else $error("direct write did not load flags");
  a_read_nochange: assert property (@(posedge clk) disable iff (!resetn)
    acc && avs_read && avs_address == irq_flag_pkg::OFS_FLAG_SETCLR
    |=> flag_q == $past(flag_q))
    else $error("flag read changed flags");
  a_view_alias: assert property (@(posedge clk) disable iff (!resetn)
    acc && avs_read && avs_address == irq_flag_pkg::OFS_FLAG_DIRECT
    |=> rdata_q[FLAG_W-1:0] == $past(flag_q) && rdata_q[31:FLAG_W] == '0)
    else $error("direct view read mismatch");
  a_polarity_xor: assert property (@(posedge clk) disable iff (!resetn)
    ##1 $changed(invert_q) |-> flag_request == (flag_q ^ invert_q))
    else $error("request not flag xor select");
  a_enable_gate: assert property (@(posedge clk) disable iff (!resetn)
    (enable_q == '0) |-> !src_all[irq_flag_pkg::SRC_FLAG_UNIT])
    else $error("masked flag request forwarded");
  a_noreq_track: assert property (@(posedge clk) disable iff (!resetn)
    any_req |=> !noreq_q ##0 cause_q == $past(pick))
    else $error("no-request bit or cause wrong");
  a_reserved_code: assert property (@(posedge clk) disable iff (!resetn)
    cause_q != irq_flag_pkg::SRC_RESERVED)
    else $error("reserved cause reported");

  // further checks on the bus answer, the status word and the cause
  // table; each one except the interrupt mask check looks one cycle after its cause,
  // so a combinational glitch on the decode cannot trip it
  // the cause checks pick one source position each and leave all lower
  // codes quiet, which pins both the code value and the lowest-wins order

  // the slave answers exactly one cycle after it accepts a request
  a_wait_once: assert property (@(posedge clk) disable iff (!resetn)
    avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held for more than one cycle");

  // set/clear view reads the live flags with reserved bits zero
  a_setclr_read: assert property (@(posedge clk) disable iff (!resetn)
    acc && avs_read && avs_address == irq_flag_pkg::OFS_FLAG_SETCLR
    |=> rdata_q[FLAG_W-1:0] == $past(flag_q) && rdata_q[31:FLAG_W] == '0)
    else $error("set/clear view read mismatch");

  // status word carries the no-request bit and cause, nothing else
  a_status_read: assert property (@(posedge clk) disable iff (!resetn)
    acc && avs_read && avs_address == irq_flag_pkg::OFS_CUR_STATUS
    |=> rdata_q[16] == $past(noreq_q) && rdata_q[4:0] == $past(cause_q)
        && rdata_q[31:17] == '0 && rdata_q[15:5] == '0)
    else $error("status read mismatch");

  // unmapped offsets answer with an error and zero data
  a_unmapped_err: assert property (@(posedge clk) disable iff (!resetn)
    acc && !hit |=> avs_response_err && rdata_q == '0)
    else $error("unmapped access not refused");

  // without any request the no-request bit comes back high
  a_noreq_idle: assert property (@(posedge clk) disable iff (!resetn)
    !any_req |=> noreq_q)
    else $error("no-request bit low without request");

  // the cause is left alone while nothing is requested
  a_cause_hold: assert property (@(posedge clk) disable iff (!resetn)
    !any_req |=> $stable(cause_q))
    else $error("cause moved without request");

  // a full polarity write loads the select word
  a_invert_load: assert property (@(posedge clk) disable iff (!resetn)
    wr_go && avs_address == irq_flag_pkg::OFS_INVERT_SEL && avs_byteenable == 4'hf
    |=> invert_q == $past(avs_writedata[FLAG_W-1:0]))
    else $error("polarity write did not load");

  // flags change only through one of the two views
  a_flag_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !(wr_go && (avs_address == irq_flag_pkg::OFS_FLAG_DIRECT
             || avs_address == irq_flag_pkg::OFS_FLAG_SETCLR))
    |=> $stable(flag_q))
    else $error("flags changed without a view write");

  // ecc error always wins as the lowest code
  a_ecc_first: assert property (@(posedge clk) disable iff (!resetn)
    src_all[0] |=> cause_q == irq_flag_pkg::SRC_ECC)
    else $error("ecc source not reported first");

  // first external input reports the external base code
  a_ext_order: assert property (@(posedge clk) disable iff (!resetn)
    src_all[1:0] == '0 && src_all[2] |=> cause_q == irq_flag_pkg::SRC_EXT_BASE)
    else $error("external input code wrong");

  // first serial port reports the serial base code
  a_serial_code: assert property (@(posedge clk) disable iff (!resetn)
    src_all[7:0] == '0 && src_all[8] |=> cause_q == irq_flag_pkg::SRC_SERIAL_BASE)
    else $error("serial port code wrong");

  // the own flag source reports its own code
  a_own_code: assert property (@(posedge clk) disable iff (!resetn)
    src_all[13:0] == '0 && src_all[14] |=> cause_q == irq_flag_pkg::SRC_FLAG_UNIT)
    else $error("own flag code wrong");

  // spi alone reports the top code
  a_spi_code: assert property (@(posedge clk) disable iff (!resetn)
    src_all == 32'h8000_0000 |=> cause_q == irq_flag_pkg::SRC_SPI)
    else $error("spi code wrong");

  // a new report leaves its sticky bit set, even against a clear
  a_report_sticky: assert property (@(posedge clk) disable iff (!resetn)
    evt_set[irq_flag_pkg::EVT_REPORT] |=> evt_q[irq_flag_pkg::EVT_REPORT])
    else $error("report event lost");

  // a clear with no new report empties the sticky bit
  a_report_clear: assert property (@(posedge clk) disable iff (!resetn)
    evt_clr[irq_flag_pkg::EVT_REPORT] && !evt_set[irq_flag_pkg::EVT_REPORT]
    |=> !evt_q[irq_flag_pkg::EVT_REPORT])
    else $error("report event not cleared");

  // an enabled flag request leaves its sticky bit set
  a_flag_sticky: assert property (@(posedge clk) disable iff (!resetn)
    evt_set[irq_flag_pkg::EVT_FLAG_REQ] |=> evt_q[irq_flag_pkg::EVT_FLAG_REQ])
    else $error("flag request event lost");

  // with every event disabled the interrupt line stays low
  a_irq_masked: assert property (@(posedge clk) disable iff (!resetn)
    evt_en_q == '0 |-> !irq)
    else $error("interrupt raised while disabled");

endmodule // irq_flag_polarity_cause

// ===== rtl/irq_flag_pkg.sv
/*
  shared constants for the interrupt flag, polarity and cause block.
  assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package irq_flag_pkg;

  localparam int          ADDR_W            = 16;
  localparam int          FLAG_W            = 16;
  localparam int          CAUSE_W           = 5;
  localparam int          NUM_SRC           = 32;

  // register byte offsets
  localparam logic [15:0] OFS_FLAG_DIRECT   = 16'hf510;
  localparam logic [15:0] OFS_FLAG_SETCLR   = 16'hf514;
  localparam logic [15:0] OFS_INVERT_SEL    = 16'hf518;
  localparam logic [15:0] OFS_SRC_ENABLE    = 16'hf51c;
  localparam logic [15:0] OFS_CUR_STATUS    = 16'hf6a0;
  localparam logic [15:0] OFS_EVT_STATUS    = 16'hf530;
  localparam logic [15:0] OFS_EVT_ENABLE    = 16'hf534;
  localparam logic [15:0] OFS_EVT_CLEAR     = 16'hf538;

  // field positions
  localparam int          CAUSE_LSB         = 0;
  localparam int          NOREQ_BIT         = 16;

  // reset values
  localparam logic [15:0] FLAG_RST          = 16'h0000;
  localparam logic [15:0] INVERT_RST        = 16'h0000;
  localparam logic [15:0] SRC_ENABLE_RST    = 16'h0000;
  localparam logic [4:0]  CAUSE_RST         = 5'h1f;

  // source codes
  localparam logic [4:0]  SRC_ECC           = 5'h00;
  localparam logic [4:0]  SRC_WR_TIMEOUT    = 5'h01;
  localparam logic [4:0]  SRC_EXT_BASE      = 5'h02;
  localparam logic [4:0]  SRC_SERIAL_BASE   = 5'h08;
  localparam logic [4:0]  SRC_DMA_A_BASE    = 5'h0a;
  localparam logic [4:0]  SRC_FLAG_UNIT     = 5'h0e;
  localparam logic [4:0]  SRC_PCI_DMA       = 5'h0f;
  localparam logic [4:0]  SRC_PCI_A         = 5'h10;
  localparam logic [4:0]  SRC_TIMER_BASE    = 5'h11;
  localparam logic [4:0]  SRC_RESERVED      = 5'h14;
  localparam logic [4:0]  SRC_NAND          = 5'h15;
  localparam logic [4:0]  SRC_PCI_ERR       = 5'h16;
  localparam logic [4:0]  SRC_PCI_PWR       = 5'h17;
  localparam logic [4:0]  SRC_AUDIO         = 5'h18;
  localparam logic [4:0]  SRC_AUDIO_PWR     = 5'h19;
  localparam logic [4:0]  SRC_PCI_B         = 5'h1a;
  localparam logic [4:0]  SRC_DMA_B_BASE    = 5'h1b;
  localparam logic [4:0]  SRC_SPI           = 5'h1f;

  // event bits of the event status register
  localparam int          EVT_REPORT        = 0;
  localparam int          EVT_FLAG_REQ      = 1;
  localparam int          EVT_W             = 2;

endpackage

// ===== bench/bus_master_model.sv
/*
  avalon-mm master standing in for the processor core and the other bus masters.
  assumes the slave answers with waitrequest and is clocked by the same clk.
*/
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic        clk,
  output logic      [15:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  output logic             avs_master_is_core,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic        avs_response_err
);
  initial begin
    avs_address        = 16'h0000;
    avs_read           = 1'b0;
    avs_write          = 1'b0;
    avs_writedata      = 32'h00000000;
    avs_byteenable     = 4'h0;
    avs_master_is_core = 1'b1;
  end

  // one access; the request is held until waitrequest is sampled low
  task automatic access(input logic wr, input logic core, input logic [15:0] a,
                        input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge clk);
    avs_address        <= a;
    avs_read           <= ~wr;
    avs_write          <= wr;
    avs_writedata      <= d;
    avs_byteenable     <= 4'hf;
    avs_master_is_core <= core;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q   = avs_readdata;
    err = avs_response_err;
    // released address, data and master id carry the inverse, strobes and enables drop low, so stale values cannot pass
    avs_read           <= 1'b0;
    avs_write          <= 1'b0;
    avs_writedata      <= ~d;
    avs_address        <= ~a;
    avs_byteenable     <= 4'h0;
    avs_master_is_core <= ~core;
  endtask
endmodule // bus_master_model

// ===== bench/testbench.sv
/*
  self-checking bench for the flag, polarity and cause block.
  assumes the bus master model drives the register bus; sources driven here.
*/
`timescale 1ns/1ns
`define CHK(w, e, g) chk(w, 32'(e), 32'(g))
module testbench;
  logic        clk;
  logic        resetn;
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic        avs_master_is_core;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        avs_response_err;
  logic [31:0] source_req;
  logic [15:0] flag_request;
  logic        core_irq;
  logic        irq;
  int          fail_count;
  int          total_checks;
  logic [31:0] q;
  logic        err;

  bus_master_model i_master (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_master_is_core(avs_master_is_core), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err));

  irq_flag_polarity_cause #(.FLAG_W(16)) i_dut (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_master_is_core(avs_master_is_core), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
    .source_req(source_req), .flag_request(flag_request), .core_irq(core_irq), .irq(irq));

  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic core);
    i_master.access(1'b1, core, a, d, q, err);
  endtask

  task automatic rd(input logic [15:0] a);
    i_master.access(1'b0, 1'b1, a, 32'h00000000, q, err);
  endtask

  // expected status word from the no-request bit and cause
  function automatic logic [31:0] stat(input logic noreq, input logic [4:0] c);
    return {15'h0000, noreq, 11'h000, c};
  endfunction

  task automatic t_reset;
    rd(irq_flag_pkg::OFS_FLAG_DIRECT); `CHK("flag reset", 32'h0, q);
    rd(irq_flag_pkg::OFS_INVERT_SEL); `CHK("select reset", 32'h0, q);
    rd(irq_flag_pkg::OFS_SRC_ENABLE); `CHK("enable reset", 32'h0, q);
    rd(irq_flag_pkg::OFS_CUR_STATUS); `CHK("status reset", stat(1'b1, 5'h1f), q);
    `CHK("core_irq reset", 1'b0, core_irq);
    $display("test reset done");
  endtask

  task automatic t_views;
    wr(irq_flag_pkg::OFS_FLAG_DIRECT, 32'hffffa5c3, 1'b1);
    rd(irq_flag_pkg::OFS_FLAG_DIRECT); `CHK("direct load", 32'h0000a5c3, q);
    rd(irq_flag_pkg::OFS_FLAG_SETCLR); `CHK("alias view", 32'h0000a5c3, q);
    `CHK("request no invert", 16'ha5c3, flag_request);
    wr(irq_flag_pkg::OFS_FLAG_SETCLR, 32'h00000f00, 1'b1);
    rd(irq_flag_pkg::OFS_FLAG_DIRECT); `CHK("core sets", 32'h0000afc3, q);
    wr(irq_flag_pkg::OFS_FLAG_SETCLR, 32'hffff00c3, 1'b0);
    rd(irq_flag_pkg::OFS_FLAG_SETCLR); `CHK("master clears", 32'h0000af00, q);
    rd(irq_flag_pkg::OFS_FLAG_SETCLR); `CHK("read no effect", 32'h0000af00, q);
    rd(16'hf600); `CHK("unmapped err", 1'b1, err);
    `CHK("unmapped data", 32'h0, q);
    wr(irq_flag_pkg::OFS_INVERT_SEL, 32'h0000ffff, 1'b1);
    @(posedge clk);
    `CHK("request inverted", 16'h50ff, flag_request);
    rd(irq_flag_pkg::OFS_INVERT_SEL); `CHK("select back", 32'h0000ffff, q);
    $display("test views done");
  endtask

  task automatic t_causes;
    for (int k = 0; k < 32; k++) begin
      if (k == 14) continue;
      source_req <= 32'h1 << k;
      repeat (2) @(posedge clk);
      rd(irq_flag_pkg::OFS_CUR_STATUS);
      // code 20 is never reported, so no request is seen for it
      if (k == 20) `CHK("reserved code", 1'b1, q[16]);
      else `CHK("cause code", stat(1'b0, 5'(k)), q);
      if (k != 20) `CHK("core_irq", 1'b1, core_irq);
    end
    source_req <= 32'h00000300;
    repeat (2) @(posedge clk);
    rd(irq_flag_pkg::OFS_CUR_STATUS); `CHK("serial order", stat(1'b0, 5'h08), q);
    source_req <= 32'h0;
    repeat (2) @(posedge clk);
    rd(irq_flag_pkg::OFS_CUR_STATUS); `CHK("no request", 1'b1, q[16]);
    $display("test causes done");
  endtask

  task automatic t_events;
    wr(irq_flag_pkg::OFS_EVT_CLEAR, 32'h3, 1'b1);
    wr(irq_flag_pkg::OFS_EVT_ENABLE, 32'h0, 1'b1);
    rd(irq_flag_pkg::OFS_EVT_STATUS); `CHK("event cleared", 32'h0, q);
    source_req <= 32'h00000020;
    repeat (2) @(posedge clk);
    rd(irq_flag_pkg::OFS_EVT_STATUS); `CHK("report event", 32'h1, q);
    `CHK("irq masked", 1'b0, irq);
    wr(irq_flag_pkg::OFS_EVT_ENABLE, 32'h1, 1'b1);
    @(posedge clk);
    `CHK("irq enabled", 1'b1, irq);
    wr(irq_flag_pkg::OFS_EVT_CLEAR, 32'h1, 1'b1);
    @(posedge clk);
    `CHK("irq cleared", 1'b0, irq);
    source_req <= 32'h0;
    repeat (2) @(posedge clk);
    $display("test events done");
  endtask

  task automatic t_own;
    wr(irq_flag_pkg::OFS_SRC_ENABLE, 32'h00000001, 1'b1);
    repeat (2) @(posedge clk);
    rd(irq_flag_pkg::OFS_CUR_STATUS); `CHK("own source", stat(1'b0, 5'h0e), q);
    rd(irq_flag_pkg::OFS_EVT_STATUS); `CHK("flag event", 32'h3, q);
    `CHK("irq own", 1'b1, irq);
    wr(irq_flag_pkg::OFS_SRC_ENABLE, 32'h00000100, 1'b1);
    repeat (2) @(posedge clk);
    rd(irq_flag_pkg::OFS_CUR_STATUS); `CHK("masked own", 1'b1, q[16]);
    $display("test own done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog: the tests need a few hundred cycles at most
  initial begin
    #(40 * 20000);
    fail_count++;
    summarize();
  end

  initial begin
    fail_count   = 0;
    total_checks = 0;
    resetn       = 1'b0;
    source_req   = 32'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_views();
    t_causes();
    t_events();
    t_own();
    summarize();
  end
endmodule // testbench
